// ### verilog/ppl_pkg.sv
package ppl_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0]  PPL_IDX_MOTOR_DIR   = 8'h45;
    localparam logic [7:0]  PPL_IDX_PAUSE_KB    = 8'h4E;
    localparam logic [7:0]  PPL_IDX_RESUME_KB   = 8'h4F;
    localparam logic [7:0]  PPL_IDX_LINES_AFTER = 8'h54;
    localparam logic [7:0]  PPL_IDX_STEP_SIZE   = 8'h60;
    localparam logic [7:0]  PPL_IDX_CONTROL     = 8'h61;
    localparam logic [7:0]  PPL_IDX_STATUS      = 8'h62;
    localparam int          PPL_ADDR_W          = 12;
    // field positions
    localparam int          PPL_DIR_BIT         = 0;
    localparam int          PPL_CTL_SCAN_EN     = 0;
    localparam int          PPL_CTL_MICRO       = 1;
    localparam int          PPL_CTL_DEPTH_LO    = 2;
    localparam int          PPL_CTL_SRAM_LO     = 4;
    localparam int          PPL_CTL_S600        = 6;
    localparam int          PPL_STAT_PAUSED     = 24;
    localparam int          PPL_STAT_FINISH     = 25;
    // reset values
    localparam logic [7:0]  PPL_RST_MOTOR_DIR   = 8'h00;
    localparam logic [7:0]  PPL_RST_PAUSE_KB    = 8'h00;
    localparam logic [7:0]  PPL_RST_RESUME_KB   = 8'h00;
    localparam logic [7:0]  PPL_RST_LINES_AFTER = 8'h00;
    localparam logic [13:0] PPL_RST_STEP_SIZE   = 14'h0000;
    localparam logic [7:0]  PPL_RST_CONTROL     = 8'h00;
    // sizes and timing
    localparam int          PPL_SRAM_AW         = 18;
    localparam int          PPL_STEP_W          = 14;
    localparam int          PPL_PIX_PERIOD_MCLK = 24;
    localparam int          PPL_USTEP_PER_FULL  = 4;
    localparam logic [9:0]  PPL_KB_LOW_FULL     = 10'h3FF;
    localparam logic [17:0] PPL_SRAM_64K        = 18'h10000;
    localparam logic [17:0] PPL_SRAM_128K       = 18'h20000;
    localparam logic [17:0] PPL_SRAM_256K       = 18'h3FFFF;
    localparam logic [17:0] PPL_COEF_300        = 18'h04000;
    localparam logic [17:0] PPL_COEF_600        = 18'h08000;
    localparam logic [2:0]  PPL_DAC_FULL        = 3'h4;
    localparam logic [1:0]  PPL_RESP_OKAY       = 2'h0;
    localparam logic [1:0]  PPL_RESP_SLVERR     = 2'h2;

    typedef enum logic [1:0] {
        PPL_DEPTH_8 = 2'h0,
        PPL_DEPTH_4 = 2'h1,
        PPL_DEPTH_2 = 2'h2,
        PPL_DEPTH_1 = 2'h3
    } ppl_depth_t;

    typedef enum logic [2:0] {
        PPL_RUN    = 3'b001,
        PPL_FINISH = 3'b010,
        PPL_PAUSED = 3'b100
    } ppl_state_t;
endpackage

// ### verilog/ppl_pack_if.sv
`timescale 1ns/10ps
interface ppl_pack_if;
    logic       pix_valid;
    logic [7:0] pix_data;
    logic       line_end;
    logic [1:0] depth;
    logic       byte_valid;
    logic [7:0] byte_data;

    modport packer (input pix_valid, input pix_data, input line_end, input depth,
                    output byte_valid, output byte_data);
    modport buffer (output pix_valid, output pix_data, output line_end, output depth,
                    input byte_valid, input byte_data);
endinterface

// ### verilog/ppl_packer.sv
`timescale 1ns/10ps
module ppl_packer
    import ppl_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    ppl_pack_if.packer pk
);
    logic [7:0] acc_q;
    logic [2:0] cnt_q;
    logic [7:0] byte_q;
    logic       bv_q;
    logic [7:0] nxt;
    logic [2:0] last_cnt;

    always_comb begin
        last_cnt = 3'((4'h1 << pk.depth) - 4'h1);
        case (pk.depth)
            PPL_DEPTH_4: nxt = {acc_q[3:0], pk.pix_data[7:4]};
            PPL_DEPTH_2: nxt = {acc_q[5:0], pk.pix_data[7:6]};
            PPL_DEPTH_1: nxt = {acc_q[6:0], pk.pix_data[7]};
            default:     nxt = pk.pix_data;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_q  <= 8'h00;
            cnt_q  <= 3'h0;
            byte_q <= 8'h00;
            bv_q   <= 1'b0;
        end else begin
            bv_q <= 1'b0;
            if (pk.pix_valid) begin
                acc_q <= nxt;
                if (cnt_q == last_cnt) begin
                    byte_q <= nxt;
                    bv_q   <= 1'b1;
                    cnt_q  <= 3'h0;
                end else if (pk.line_end) begin
                    cnt_q <= 3'h0;
                end else begin
                    cnt_q <= cnt_q + 3'h1;
                end
            end
        end
    end

    assign pk.byte_valid = bv_q;
    assign pk.byte_data  = byte_q;
endmodule

// ### verilog/ppl_line_buffer.sv
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/10ps
module ppl_line_buffer
    import ppl_pkg::*;
#(
    parameter int STEP_W = PPL_STEP_W
)(
    input  wire logic                   clock,
    input  wire logic                   rst,
    input  wire logic [PPL_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [PPL_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   pix_valid,
    input  wire logic [7:0]             pix_data,
    input  wire logic                   pix_line_end,
    output logic                        pix_ready,
    output logic [PPL_SRAM_AW-1:0]      sram_addr,
    output logic [7:0]                  sram_wdata,
    output logic                        sram_we,
    output logic                        sram_re,
    input  wire logic [7:0]             sram_rdata,
    output logic [7:0]                  host_data,
    output logic                        host_valid,
    input  wire logic                   host_ready,
    output logic                        pause_req,
    output logic                        resume_req,
    output logic                        motor_a,
    output logic                        motor_a_n,
    output logic                        motor_b,
    output logic                        motor_b_n,
    output logic [2:0]                  dac_a,
    output logic [2:0]                  dac_b
);
    ppl_pack_if pk ();

    // register file
    logic [7:0]        dir_q;
    logic [7:0]        pause_kb_q;
    logic [7:0]        resume_kb_q;
    logic [7:0]        lines_after_q;
    logic [STEP_W-1:0] step_size_q;
    logic [7:0]        ctrl_q;

    // bus slave
    logic                  aw_held_q;
    logic                  w_held_q;
    logic [PPL_ADDR_W-1:0] awaddr_q;
    logic [31:0]           wdata_q;
    logic [3:0]            wstrb_q;
    logic                  bvalid_q;
    logic [1:0]            bresp_q;
    logic                  rvalid_q;
    logic [31:0]           rdata_q;
    logic [1:0]            rresp_q;
    logic                  do_write;
    logic [7:0]            w_idx;
    logic [7:0]            r_idx;

    // buffer
    ppl_state_t           state_q;
    logic [17:0]          fill_q;
    logic [17:0]          wr_off_q;
    logic [17:0]          rd_off_q;
    logic [2:0]           lines_left_q;
    logic                 rd_pend_q;
    logic [7:0]           host_data_q;
    logic                 host_valid_q;
    logic [17:0]          sram_bytes;
    logic [17:0]          coef_bytes;
    logic [17:0]          buf_size;
    logic                 accepting;
    logic                 do_rd;
    logic                 pause_hit;
    logic                 resume_hit;
    logic                 pause_q;
    logic                 resume_q;

    // motor timebase
    logic [4:0]        pix_div_q;
    logic              pix_tick;
    logic [STEP_W-1:0] step_cnt_q;
    logic              ustep_tick;
    logic [3:0]        ustep_q;
    logic [3:0]        pos_a;
    logic [3:0]        pos_b;
    logic              motor_run;
    logic              ma_q;
    logic              man_q;
    logic              mb_q;
    logic              mbn_q;
    logic [2:0]        da_q;
    logic [2:0]        db_q;

    ppl_packer u_packer (
        .clock (clock),
        .rst   (rst),
        .pk    (pk)
    );

    assign pk.pix_valid = pix_valid & pix_ready;
    assign pk.pix_data  = pix_data;
    assign pk.line_end  = pix_line_end;
    assign pk.depth     = ctrl_q[PPL_CTL_DEPTH_LO+1:PPL_CTL_DEPTH_LO];

    // write channel: address and data taken in either order
    assign s_axi_awready = ~aw_held_q & ~bvalid_q;
    assign s_axi_wready  = ~w_held_q & ~bvalid_q;
    assign do_write      = aw_held_q & w_held_q & ~bvalid_q;
    assign w_idx         = awaddr_q[9:2];
    assign r_idx         = s_axi_araddr[9:2];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= PPL_RESP_OKAY;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                if (awaddr_q[PPL_ADDR_W-1:10] == '0 && (w_idx == PPL_IDX_MOTOR_DIR
                    || w_idx == PPL_IDX_PAUSE_KB || w_idx == PPL_IDX_RESUME_KB
                    || w_idx == PPL_IDX_LINES_AFTER || w_idx == PPL_IDX_STEP_SIZE
                    || w_idx == PPL_IDX_CONTROL || w_idx == PPL_IDX_STATUS)) begin
                    bresp_q <= PPL_RESP_OKAY;
                end else begin
                    bresp_q <= PPL_RESP_SLVERR;
                end
            end else if (bvalid_q & s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dir_q         <= PPL_RST_MOTOR_DIR;
            pause_kb_q    <= PPL_RST_PAUSE_KB;
            resume_kb_q   <= PPL_RST_RESUME_KB;
            lines_after_q <= PPL_RST_LINES_AFTER;
            step_size_q   <= PPL_RST_STEP_SIZE;
            ctrl_q        <= PPL_RST_CONTROL;
        end else if (do_write && awaddr_q[PPL_ADDR_W-1:10] == '0) begin
            if (w_idx == PPL_IDX_MOTOR_DIR && wstrb_q[0]) begin
                dir_q <= wdata_q[7:0];
            end else if (w_idx == PPL_IDX_PAUSE_KB && wstrb_q[0]) begin
                pause_kb_q <= wdata_q[7:0];
            end else if (w_idx == PPL_IDX_RESUME_KB && wstrb_q[0]) begin
                resume_kb_q <= wdata_q[7:0];
            end else if (w_idx == PPL_IDX_LINES_AFTER && wstrb_q[0]) begin
                lines_after_q <= wdata_q[7:0];
            end else if (w_idx == PPL_IDX_STEP_SIZE) begin
                if (wstrb_q[0]) begin
                    step_size_q[7:0] <= wdata_q[7:0];
                end
                if (wstrb_q[1]) begin
                    step_size_q[STEP_W-1:8] <= wdata_q[STEP_W-1:8];
                end
            end else if (w_idx == PPL_IDX_CONTROL && wstrb_q[0]) begin
                ctrl_q <= wdata_q[7:0];
            end
        end
    end

    // read channel
    assign s_axi_arready = ~rvalid_q;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= PPL_RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= PPL_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
            if (s_axi_araddr[PPL_ADDR_W-1:10] != '0) begin
                rresp_q <= PPL_RESP_SLVERR;
            end else if (r_idx == PPL_IDX_MOTOR_DIR) begin
                rdata_q[7:0] <= dir_q;
            end else if (r_idx == PPL_IDX_PAUSE_KB) begin
                rdata_q[7:0] <= pause_kb_q;
            end else if (r_idx == PPL_IDX_RESUME_KB) begin
                rdata_q[7:0] <= resume_kb_q;
            end else if (r_idx == PPL_IDX_LINES_AFTER) begin
                rdata_q[7:0] <= lines_after_q;
            end else if (r_idx == PPL_IDX_STEP_SIZE) begin
                rdata_q[STEP_W-1:0] <= step_size_q;
            end else if (r_idx == PPL_IDX_CONTROL) begin
                rdata_q[7:0] <= ctrl_q;
            end else if (r_idx == PPL_IDX_STATUS) begin
                rdata_q[17:0]            <= fill_q;
                rdata_q[PPL_STAT_PAUSED] <= (state_q == PPL_PAUSED);
                rdata_q[PPL_STAT_FINISH] <= (state_q == PPL_FINISH);
            end else begin
                rresp_q <= PPL_RESP_SLVERR;
            end
        end else if (rvalid_q & s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // buffer area geometry
    always_comb begin
        case (ctrl_q[PPL_CTL_SRAM_LO+1:PPL_CTL_SRAM_LO])
            2'h0:    sram_bytes = PPL_SRAM_64K;
            2'h1:    sram_bytes = PPL_SRAM_128K;
            default: sram_bytes = PPL_SRAM_256K;
        endcase
        coef_bytes = ctrl_q[PPL_CTL_S600] ? PPL_COEF_600 : PPL_COEF_300;
        buf_size   = sram_bytes - coef_bytes;
    end

    // one packed byte may be in flight, so keep one slot spare
    assign accepting = (state_q != PPL_PAUSED) && (fill_q < buf_size - 18'h1);
    assign pix_ready = accepting;
    assign do_rd     = ~pk.byte_valid & (fill_q != 18'h0) & ~rd_pend_q & ~host_valid_q;

    // single SRAM port, packer writes win
    assign sram_we    = pk.byte_valid;
    assign sram_re    = do_rd;
    assign sram_wdata = pk.byte_data;
    assign sram_addr  = coef_bytes + (pk.byte_valid ? wr_off_q : rd_off_q);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_off_q <= 18'h0;
            rd_off_q <= 18'h0;
            fill_q   <= 18'h0;
        end else begin
            if (pk.byte_valid) begin
                wr_off_q <= (wr_off_q == buf_size - 18'h1) ? 18'h0 : wr_off_q + 18'h1;
                fill_q   <= fill_q + 18'h1;
            end else if (do_rd) begin
                rd_off_q <= (rd_off_q == buf_size - 18'h1) ? 18'h0 : rd_off_q + 18'h1;
                fill_q   <= fill_q - 18'h1;
            end
        end
    end

    // host output stage, sync SRAM read data one cycle later
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_pend_q    <= 1'b0;
            host_valid_q <= 1'b0;
            host_data_q  <= 8'h00;
        end else begin
            rd_pend_q <= do_rd;
            if (rd_pend_q) begin
                host_valid_q <= 1'b1;
                host_data_q  <= sram_rdata;
            end else if (host_valid_q & host_ready) begin
                host_valid_q <= 1'b0;
            end
        end
    end

    assign host_valid = host_valid_q;
    assign host_data  = host_data_q;

    // pause and resume flow
    assign pause_hit  = fill_q == {pause_kb_q, 10'h000};
    assign resume_hit = fill_q == {resume_kb_q, PPL_KB_LOW_FULL};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_q      <= PPL_RUN;
            lines_left_q <= 3'h0;
            pause_q      <= 1'b0;
            resume_q     <= 1'b0;
        end else begin
            pause_q  <= 1'b0;
            resume_q <= 1'b0;
            if (!ctrl_q[PPL_CTL_SCAN_EN]) begin
                state_q <= PPL_RUN;
            end else begin
                case (state_q)
                    PPL_RUN: begin
                        if (pause_hit) begin
                            pause_q      <= 1'b1;
                            lines_left_q <= lines_after_q[2:0];
                            state_q      <= PPL_FINISH;
                        end
                    end
                    PPL_FINISH: begin
                        if (pix_valid & pix_ready & pix_line_end) begin
                            if (lines_left_q == 3'h0) begin
                                state_q <= PPL_PAUSED;
                            end else begin
                                lines_left_q <= lines_left_q - 3'h1;
                            end
                        end
                    end
                    PPL_PAUSED: begin
                        if (resume_hit) begin
                            resume_q <= 1'b1;
                            state_q  <= PPL_RUN;
                        end
                    end
                    default: state_q <= PPL_RUN;
                endcase
            end
        end
    end

    assign pause_req  = pause_q;
    assign resume_req = resume_q;

    // pixel period and microstep timebase
    assign pix_tick   = pix_div_q == 5'(PPL_PIX_PERIOD_MCLK - 1);
    assign motor_run  = ctrl_q[PPL_CTL_SCAN_EN] && state_q == PPL_RUN;
    assign ustep_tick = motor_run && pix_tick && step_size_q != '0
                        && step_cnt_q == step_size_q - 1'b1;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pix_div_q <= 5'h00;
        end else begin
            pix_div_q <= pix_tick ? 5'h00 : pix_div_q + 5'h01;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            step_cnt_q <= '0;
            ustep_q    <= 4'h0;
        end else if (!motor_run) begin
            step_cnt_q <= '0;
        end else if (pix_tick) begin
            step_cnt_q <= ustep_tick ? '0 : step_cnt_q + 1'b1;
            if (ustep_tick) begin
                ustep_q <= ustep_q + 4'h1;
            end
        end
    end

    // phase b sits four microsteps (quarter cycle) from phase a
    always_comb begin
        pos_a = ustep_q;
        if (!ctrl_q[PPL_CTL_MICRO]) begin
            pos_a = {ustep_q[3:2], 2'h2};
        end
        pos_b = dir_q[PPL_DIR_BIT] ? pos_a - 4'(PPL_USTEP_PER_FULL)
                                   : pos_a + 4'(PPL_USTEP_PER_FULL);
    end

    function automatic logic [2:0] ppl_sine_mag(input logic [3:0] p);
        logic [2:0] m;
        m = p[2] ? 3'(4'h8 - {1'b0, p[2:0]}) : p[2:0];
        return m;
    endfunction

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ma_q  <= 1'b0;
            man_q <= 1'b0;
            mb_q  <= 1'b0;
            mbn_q <= 1'b0;
            da_q  <= 3'h0;
            db_q  <= 3'h0;
        end else if (!ctrl_q[PPL_CTL_SCAN_EN]) begin
            ma_q  <= 1'b0;
            man_q <= 1'b0;
            mb_q  <= 1'b0;
            mbn_q <= 1'b0;
            da_q  <= 3'h0;
            db_q  <= 3'h0;
        end else if (ctrl_q[PPL_CTL_MICRO]) begin
            da_q  <= ppl_sine_mag(pos_a);
            db_q  <= ppl_sine_mag(pos_b);
            ma_q  <= ~pos_a[3] & (ppl_sine_mag(pos_a) != 3'h0);
            man_q <= pos_a[3] & (ppl_sine_mag(pos_a) != 3'h0);
            mb_q  <= ~pos_b[3] & (ppl_sine_mag(pos_b) != 3'h0);
            mbn_q <= pos_b[3] & (ppl_sine_mag(pos_b) != 3'h0);
        end else begin
            da_q  <= PPL_DAC_FULL;
            db_q  <= PPL_DAC_FULL;
            ma_q  <= ~pos_a[3];
            man_q <= pos_a[3];
            mb_q  <= ~pos_b[3];
            mbn_q <= pos_b[3];
        end
    end

    assign motor_a   = ma_q;
    assign motor_a_n = man_q;
    assign motor_b   = mb_q;
    assign motor_b_n = mbn_q;
    assign dac_a     = da_q;
    assign dac_b     = db_q;
endmodule

// ### sim/ppl_sram_model.sv
`timescale 1ns/10ps
module ppl_sram_model (
    input  wire logic        clock,
    input  wire logic [17:0] sram_addr,
    input  wire logic [7:0]  sram_wdata,
    input  wire logic        sram_we,
    input  wire logic        sram_re,
    output logic [7:0]       sram_rdata
);
    logic [7:0] mem [262144];
    logic [7:0] rd_q = 8'h00;
    logic       re_q = 1'b0;
    always @(posedge clock) begin
        if (sram_we) mem[sram_addr] <= sram_wdata;
        if (sram_re) rd_q <= mem[sram_addr];
        re_q <= sram_re;
    end
    // sync read: byte stands the cycle after the strobe, inverse otherwise
    assign sram_rdata = re_q ? rd_q : ~rd_q;
endmodule

// ### sim/ppl_line_buffer_monitor.sv
`timescale 1ns/10ps
module ppl_line_buffer_monitor (
    input wire logic       clock,
    input wire logic       rst,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       pix_valid,
    input wire logic       pix_ready,
    input wire logic       sram_we,
    input wire logic       sram_re,
    input wire logic       host_valid,
    input wire logic       host_ready,
    input wire logic [7:0] host_data,
    input wire logic       pause_req,
    input wire logic       resume_req
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence fetch_s; sram_re ##2 host_valid; endsequence
    pause_pulse_a: assert property (pause_req |=> !pause_req) else $error("pause too long");
    resume_pulse_a: assert property (resume_req |=> !resume_req) else $error("resume too long");
    req_excl_a: assert property (!(pause_req && resume_req)) else $error("both requests");
    write_cause_a: assert property (sram_we |-> $past(pix_valid && pix_ready)) else $error("stray write");
    fetch_a: assert property (sram_re |-> fetch_s) else $error("fetch lost");
    no_clash_a: assert property (!(sram_we && sram_re)) else $error("read and write");
    host_hold_a: assert property (host_valid && !host_ready |=> host_valid && $stable(host_data))
        else $error("host byte dropped");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no rvalid");
endmodule

// ### sim/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; $display("mismatch %0t %h %h", $time, a, b); end end
module tb_top;
    import ppl_pkg::*;
    logic        clock = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic        s_axi_rready = 0, pix_valid = 0, pix_line_end = 0, host_ready = 1;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [7:0]  pix_data = 0, sram_wdata, sram_rdata, host_data, wq[$], hq[$], eq[$];
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [17:0] sram_addr;
    logic [2:0]  dac_a, dac_b;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pix_ready, sram_we;
    logic        sram_re, host_valid, pause_req, resume_req, motor_a, motor_a_n, motor_b, motor_b_n;
    int          err_count = 0, num_checks = 0, cyc = 0, n_pause = 0, n_resume = 0;
    ppl_line_buffer i_ppl_line_buffer (.*);
    ppl_sram_model i_ppl_sram_model (.*);
    always #50 clock = ~clock;
    always @(posedge clock) begin
        cyc++;
        n_pause += int'(pause_req);
        n_resume += int'(resume_req);
        if (sram_we) wq.push_back(sram_wdata);
        if (host_valid && host_ready) hq.push_back(host_data);
        if (cyc == 5000) begin
            err_count++;
            final_report();
        end
    end
    task automatic final_report;
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [9:0] ix, input logic [31:0] d, output logic [33:0] q);
        logic ta, tw, tr, dn;
        @(posedge clock);
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        s_axi_awaddr <= {ix, 2'h0};
        s_axi_araddr <= {ix, 2'h0};
        s_axi_wdata <= d;
        do begin
            @(posedge clock);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tr = s_axi_arvalid && s_axi_arready;
            dn = s_axi_bvalid || s_axi_rvalid;
            q = w ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            if (tr) s_axi_arvalid <= 1'h0;
        end while (!dn);
        s_axi_bready <= 1'h0;
        s_axi_rready <= 1'h0;
    endtask
    task automatic px(input logic [7:0] d, input logic le);
        pix_valid <= 1'h1;
        pix_data <= d;
        pix_line_end <= le;
        do @(negedge clock); while (!pix_ready);
        @(posedge clock);
    endtask
    task automatic t_regs;
        logic [7:0]  ix [4] = '{PPL_IDX_MOTOR_DIR, PPL_IDX_PAUSE_KB, PPL_IDX_RESUME_KB, PPL_IDX_LINES_AFTER};
        logic [33:0] q;
        for (int k = 0; k < 4; k++) begin
            bus(1'h0, ix[k], 32'h0, q);
            `CHK(q, 34'h0)
            bus(1'h1, ix[k], 32'(k + 1), q);
            bus(1'h0, ix[k], 32'h0, q);
            `CHK(q, 34'(k + 1))
        end
        bus(1'h0, 10'h3F0, 32'h0, q);
        `CHK(q, {PPL_RESP_SLVERR, 32'h0})
    endtask
    task automatic t_pack;
        logic [7:0]  acc, p;
        logic [33:0] q;
        int          w, n;
        bus(1'h1, PPL_IDX_PAUSE_KB, 32'hFF, q);
        for (int dp = 0; dp < 4; dp++) begin
            bus(1'h1, PPL_IDX_CONTROL, 32'(dp << PPL_CTL_DEPTH_LO) | 32'h1, q);
            w = 8 >> dp;
            n = 0;
            wq = {};
            hq = {};
            eq = {};
            for (int i = 0; i < 11; i++) begin
                p = 8'(8'h3C + i * 8'h2B);
                acc = 8'((acc << w) | (p >> (8 - w)));
                n++;
                if (n * w == 8) begin
                    eq.push_back(acc);
                    n = 0;
                end
                if (i == 7 || i == 10) n = 0;
                px(p, i == 7 || i == 10);
            end
            pix_valid <= 1'h0;
            repeat (150) @(posedge clock);
            `CHK(wq.size(), eq.size())
            `CHK(hq.size(), eq.size())
            foreach (eq[j]) `CHK({wq[j], hq[j]}, {eq[j], eq[j]})
        end
    endtask
    task automatic t_pause;
        logic [33:0] q;
        bus(1'h1, PPL_IDX_CONTROL, 32'h0, q);
        bus(1'h1, PPL_IDX_PAUSE_KB, 32'h0, q);
        bus(1'h1, PPL_IDX_RESUME_KB, 32'h0, q);
        bus(1'h1, PPL_IDX_LINES_AFTER, 32'h0, q);
        host_ready <= 1'h0;
        bus(1'h1, PPL_IDX_CONTROL, 32'h1, q);
        repeat (3) @(posedge clock);
        `CHK(n_pause, 1)
        for (int i = 0; i < 1024; i++) px(8'(i), i == 1023);
        pix_valid <= 1'h0;
        repeat (10) @(posedge clock);
        `CHK({n_pause, n_resume}, {32'd1, 32'd1})
        bus(1'h0, PPL_IDX_STATUS, 32'h0, q);
        `CHK({q[PPL_STAT_PAUSED], q[17:0]}, 19'h003FF)
        `CHK({motor_a, motor_a_n, motor_b, motor_b_n, dac_a, dac_b}, 10'h264)
        bus(1'h1, PPL_IDX_STEP_SIZE, 32'h1, q);
        repeat (48) @(posedge clock);
        `CHK({motor_a, motor_a_n, motor_b, motor_b_n}, 4'h9)
        repeat (96) @(posedge clock);
        `CHK({motor_a, motor_a_n, motor_b, motor_b_n}, 4'hA)
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'h0;
        t_regs();
        t_pack();
        t_pause();
        final_report();
    end
endmodule
bind ppl_line_buffer ppl_line_buffer_monitor i_ppl_line_buffer_monitor (.*);
